// file: hdl/scag_top.sv
// Stack check and effective address generator
// Summary of operation
// - Stack pointer holds first free word; stack grows upward.
// - Push writes at pointer then increments; pop decrements then reads.
// - Call push clears the top bit of the pushed upper PC part.
// - Exception push places status low byte beside the upper PC part.
// - Stack limit resets to 0xfffe until software sets it.
// - Stack limit bit 0 always reads zero.
// - Every stack-pointer-based address is compared against the limit.
// - Push at pointer equal to limit passes; the next push traps.
// - Stack address below 0x0800 raises the stack error trap.
// - File direct address comes from a 13-bit field, low 8192 bytes.
// - File instructions use working register zero as implicit register.
// - Transfer instruction reaches the whole data space.
// - Three-operand: first operand direct register; second register, memory, literal.
// - Register indirect uses the pointer unchanged as address.
// - Post-modified uses pointer, then steps pointer by a constant.
// - Pre-modified adds signed constant first, uses updated value.
// - Indexed address is base pointer plus offset working register.
// - Literal offset address is base pointer plus instruction literal.
// - Enabled boot secure RAM only reachable from boot flash code.
// - Enabled general secure RAM only reachable from secure flash code.
`timescale 1ns/1ps
module scag_top
   import scag_pkg::*;
(
   // Clock and reset
   input  wire logic        clk_sys,
   input  wire logic        rst,
   // Request from decode
   input  wire logic        reqValid,
   input  wire logic [7:0]  reqMode,
   input  wire logic [3:0]  basePointerReg,
   input  wire logic [3:0]  offsetWorkingReg,
   input  wire logic [15:0] reqLiteral,
   input  wire logic [12:0] fileAddr,
   input  wire logic        transferInstruction,
   input  wire logic        fileToWorkingReg,
   input  wire logic [15:0] resultData,
   input  wire logic        stackOp,
   input  wire logic [3:0]  stackKind,
   input  wire logic [15:0] pushValue,
   input  wire logic [7:0]  statusLowByte,
   // Working register write from the core
   input  wire logic        wregWrEn,
   input  wire logic [3:0]  wregWrSel,
   input  wire logic [15:0] wregWrData,
   // Stack limit load
   input  wire logic        limitWrEn,
   input  wire logic [15:0] limitWrData,
   // Secure RAM windows and code origin
   input  wire logic        bootRamEn,
   input  wire logic [15:0] bootRamLo,
   input  wire logic [15:0] bootRamHi,
   input  wire logic        secRamEn,
   input  wire logic [15:0] secRamLo,
   input  wire logic [15:0] secRamHi,
   input  wire logic        execBootFlash,
   input  wire logic        execSecFlash,
   // Memory bus
   output logic             memValid,
   output logic             memWrite,
   output logic [15:0]      effectiveAddress,
   output logic [15:0]      memWrData,
   // Operand, stack limit and exception outputs
   output logic [15:0]      operandA,
   output logic [15:0]      stackLimitReg,
   output logic             stackErrorTrap,
   output logic             secureViolation
);
   typedef struct packed
   {
      logic [15:0] limit;
      logic        memValid;
      logic        memWrite;
      logic [15:0] ea;
      logic [15:0] wdata;
      logic [15:0] opA;
      logic        trap;
      logic        secViol;
   } scag_top_s;

   scag_top_s state_q;
   scag_top_s state_d;

   scag_default_working_reg_if wif ();

   scag_default_working_reg_file u_default_working_reg
   (
      .clk_sys (clk_sys),
      .rst     (rst),
      .port    (wif)
   );

   function automatic logic inWindow(input logic [15:0] a, input logic [15:0] lo,
                                     input logic [15:0] hi);
      inWindow = (a >= lo) && (a <= hi);
   endfunction

   // Pointer reads are combinational on the request selects from the
   // registered working registers, so back-to-back requests see updates.
   logic [15:0] ptr;
   logic [15:0] ofs;
   logic [15:0] sp;
   logic [15:0] eaNow;
   logic        isStack;
   logic        isPush;
   logic        ptrWr;
   logic [15:0] ptrNew;
   logic        stkErr;
   logic [15:0] pushWord;
   logic        bootHit;
   logic        secHit;

   assign wif.rdSelA = basePointerReg;
   assign wif.rdSelB = offsetWorkingReg;
   assign ptr        = wif.rdDataA;
   assign ofs        = wif.rdDataB;
   assign sp         = wif.spValue;

   always_comb
   begin
      eaNow    = ptr;
      ptrWr    = 1'b0;
      ptrNew   = ptr;
      isStack  = 1'b0;
      isPush   = 1'b0;
      pushWord = pushValue;
      case (reqMode)
         MODE_FILE:
         begin
            eaNow = {3'h0, fileAddr};
         end
         MODE_DIRECT:
         begin
            eaNow = ptr;
         end
         MODE_IND:
         begin
            eaNow = ptr;
         end
         MODE_POST:
         begin
            eaNow  = ptr;
            ptrWr  = 1'b1;
            ptrNew = ptr + reqLiteral;
         end
         MODE_PRE:
         begin
            ptrNew = ptr + reqLiteral;
            eaNow  = ptrNew;
            ptrWr  = 1'b1;
         end
         MODE_INDEX:
         begin
            eaNow = ptr + ofs;
         end
         MODE_LITOFS:
         begin
            eaNow = ptr + reqLiteral;
         end
         MODE_STACK:
         begin
            isStack = 1'b1;
            ptrWr   = 1'b1;
            case (stackKind)
               STK_POP:
               begin
                  ptrNew = sp - WORD_STEP;
                  eaNow  = ptrNew;
               end
               STK_CALL_PUSH:
               begin
                  isPush   = 1'b1;
                  eaNow    = sp;
                  ptrNew   = sp + WORD_STEP;
                  pushWord = {1'b0, pushValue[14:0]};
               end
               STK_EXC_PUSH:
               begin
                  isPush   = 1'b1;
                  eaNow    = sp;
                  ptrNew   = sp + WORD_STEP;
                  pushWord = {statusLowByte, pushValue[7:0]};
               end
               default:
               begin
                  isPush = 1'b1;
                  eaNow  = sp;
                  ptrNew = sp + WORD_STEP;
               end
            endcase
         end
         default:
         begin
            eaNow = ptr;
         end
      endcase
   end

   // Limit equal lets the access through; any stack access beyond it traps, as does one below STACK_FLOOR.
   assign stkErr = reqValid && (isStack || (basePointerReg == SP_INDEX && reqMode != MODE_FILE
                   && reqMode != MODE_DIRECT))
                   && ((eaNow > state_q.limit) || (eaNow < STACK_FLOOR));

   assign bootHit = bootRamEn && inWindow(eaNow, bootRamLo, bootRamHi) && !execBootFlash;
   assign secHit  = secRamEn && inWindow(eaNow, secRamLo, secRamHi) && !execSecFlash;

   // Pointer updates take priority over a core write to the same cycle
   always_comb
   begin
      wif.wrEn   = wregWrEn;
      wif.wrSel  = wregWrSel;
      wif.wrData = wregWrData;
      if (reqValid && ptrWr && !stkErr)
      begin
         wif.wrEn   = 1'b1;
         wif.wrSel  = isStack ? SP_INDEX : basePointerReg;
         wif.wrData = ptrNew;
      end
      else if (reqValid && reqMode == MODE_FILE && fileToWorkingReg)
      begin
         wif.wrEn   = 1'b1;
         wif.wrSel  = WREG0_INDEX;
         wif.wrData = resultData;
      end
   end

   always_comb
   begin
      state_d          = state_q;
      state_d.trap     = stkErr;
      state_d.secViol  = reqValid && (bootHit || secHit);
      state_d.memValid = reqValid && !stkErr && !bootHit && !secHit && reqMode != MODE_DIRECT;
      state_d.memWrite = isPush || (reqMode == MODE_FILE && !fileToWorkingReg);
      state_d.ea       = eaNow;
      state_d.wdata    = isPush ? pushWord : resultData;
      state_d.opA      = ptr;
      if (transferInstruction && reqMode == MODE_LITOFS)
      begin
         state_d.ea = ptr + reqLiteral;
      end
      if (limitWrEn)
      begin
         state_d.limit = {limitWrData[15:1], 1'b0};
      end
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         // Limit comes up at the top so only the floor check traps before software loads it
         state_q       <= '0;
         state_q.limit <= 16'hfffe;
      end
      else
      begin
         state_q <= state_d;
      end
   end

   assign memValid         = state_q.memValid;
   assign memWrite         = state_q.memWrite;
   assign effectiveAddress = state_q.ea;
   assign memWrData        = state_q.wdata;
   assign operandA         = state_q.opA;
   assign stackLimitReg    = state_q.limit;
   assign stackErrorTrap   = state_q.trap;
   assign secureViolation  = state_q.secViol;

   a_limit_lsb_zero: assert property (@(posedge clk_sys) disable iff (rst)
      stackLimitReg[0] == 1'b0) else $error("limit bit 0 set");
   a_trap_one_cycle: assert property (@(posedge clk_sys) disable iff (rst)
      $rose(stackErrorTrap) |-> ##1 (!stackErrorTrap || $past(stkErr)))
      else $error("trap not tied to cause");
   a_floor_trap: assert property (@(posedge clk_sys) disable iff (rst)
      (reqValid && isStack && eaNow < STACK_FLOOR) |=> stackErrorTrap)
      else $error("underflow missed");
   a_equal_push_ok: assert property (@(posedge clk_sys) disable iff (rst)
      (reqValid && isPush && eaNow == state_q.limit && eaNow >= STACK_FLOOR)
      |=> !stackErrorTrap) else $error("push at limit trapped");
   a_push_over_trap: assert property (@(posedge clk_sys) disable iff (rst)
      (reqValid && isPush && eaNow > state_q.limit) |=> stackErrorTrap)
      else $error("push over limit missed");
   a_call_msb_clr: assert property (@(posedge clk_sys) disable iff (rst)
      (reqValid && reqMode == MODE_STACK && stackKind == STK_CALL_PUSH)
      |=> !memWrData[15]) else $error("call push msb set");
   a_file_range: assert property (@(posedge clk_sys) disable iff (rst)
      (reqValid && reqMode == MODE_FILE) |=> effectiveAddress < 16'h2000)
      else $error("file address out of range");
   a_pre_uses_new: assert property (@(posedge clk_sys) disable iff (rst)
      (reqValid && reqMode == MODE_PRE) |=> effectiveAddress == $past(ptrNew))
      else $error("pre-modify address wrong");
   a_boot_gate: assert property (@(posedge clk_sys) disable iff (rst)
      (reqValid && bootHit) |=> (secureViolation && !memValid))
      else $error("boot ram not gated");
endmodule

// file: hdl/scag_pkg.sv
// Package: constants and types for the stack check and address generator
package scag_pkg;
   localparam int unsigned DATA_W        = 16;
   localparam int unsigned NUM_DEFAULT_WORKING_REG      = 16;
   localparam int unsigned WSEL_W        = 4;
   localparam int unsigned FILE_ADDR_W   = 13;
   localparam int unsigned LIT5_W        = 5;
   localparam logic [3:0]  SP_INDEX      = 4'hf;
   localparam logic [3:0]  WREG0_INDEX   = 4'h0;
   localparam logic [15:0] STACK_FLOOR   = 16'h0800;
   localparam logic [15:0] WORD_STEP     = 16'h0002;
   localparam logic [15:0] DEFAULT_WORKING_REG_RESET    = 16'h0000;
   localparam logic [15:0] SP_RESET      = 16'h0800;
   localparam int unsigned STACK_LIMIT_REG_LSB_POS = 0;

   // Address modes, one-hot
   typedef enum logic [7:0]
   {
      MODE_FILE   = 8'h01,
      MODE_DIRECT = 8'h02,
      MODE_IND    = 8'h04,
      MODE_POST   = 8'h08,
      MODE_PRE    = 8'h10,
      MODE_INDEX  = 8'h20,
      MODE_LITOFS = 8'h40,
      MODE_STACK  = 8'h80
   } scag_mode_e;

   // Stack operations, one-hot
   typedef enum logic [3:0]
   {
      STK_PUSH      = 4'h1,
      STK_POP       = 4'h2,
      STK_CALL_PUSH = 4'h4,
      STK_EXC_PUSH  = 4'h8
   } scag_stk_e;
endpackage

// file: hdl/scag_default_working_reg_if.sv
// Interface: working register file port between the generator and its store
`timescale 1ns/1ps
interface scag_default_working_reg_if;
   logic [3:0]  rdSelA;
   logic [3:0]  rdSelB;
   logic [15:0] rdDataA;
   logic [15:0] rdDataB;
   logic        wrEn;
   logic [3:0]  wrSel;
   logic [15:0] wrData;
   logic [15:0] spValue;
   modport user  (output rdSelA, rdSelB, wrEn, wrSel, wrData,
                  input rdDataA, rdDataB, spValue);
   modport store (input rdSelA, rdSelB, wrEn, wrSel, wrData,
                  output rdDataA, rdDataB, spValue);
endinterface

// file: hdl/scag_default_working_reg_file.sv
// Working register file; read ports select straight from the register array
`timescale 1ns/1ps
module scag_default_working_reg_file
   import scag_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // Register port
   scag_default_working_reg_if.store port
);
   typedef struct packed
   {
      logic [NUM_DEFAULT_WORKING_REG-1:0][15:0] regs;
   } scag_wf_s;

   scag_wf_s state_q;
   scag_wf_s state_d;

   always_comb
   begin
      state_d = state_q;
      if (port.wrEn)
      begin
         state_d.regs[port.wrSel] = port.wrData;
      end
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         state_q      <= '0;
         state_q.regs[SP_INDEX] <= SP_RESET;
      end
      else
      begin
         state_q <= state_d;
      end
   end

   // Selects arrive with the request, so the read cannot wait a cycle;
   // a pointer written at one edge is seen by the request after it
   assign port.rdDataA = state_q.regs[port.rdSelA];
   assign port.rdDataB = state_q.regs[port.rdSelB];
   assign port.spValue = state_q.regs[SP_INDEX];
endmodule

// file: sim/scag_decode_model.sv
// Decode-side model that issues address and stack requests to the generator
`timescale 1ns/1ps
module scag_decode_model
   import scag_pkg::*;
(
   // Clock
   input  wire logic        clk_sys,
   // Request to the generator
   output logic             reqValid,
   output logic [7:0]       reqMode,
   output logic [3:0]       basePointerReg,
   output logic [3:0]       offsetWorkingReg,
   output logic [15:0]      reqLiteral,
   output logic [12:0]      fileAddr,
   output logic [3:0]       stackKind,
   output logic [15:0]      pushValue,
   output logic [7:0]       statusLowByte,
   // Stack limit load
   output logic             limitWrEn,
   output logic [15:0]      limitWrData
);
   logic limitFresh;

   initial
   begin
      {reqValid, reqMode, basePointerReg, offsetWorkingReg, reqLiteral, fileAddr} = '0;
      {stackKind, pushValue, statusLowByte, limitWrEn, limitWrData, limitFresh} = '0;
   end

   task automatic send(input logic [7:0] m, input logic [3:0] b, o,
                       input logic [15:0] lit, pv, input logic [3:0] k, input logic [7:0] slb);
      @(posedge clk_sys);
      #1;
      limitWrEn = 1'b0;
      // A stack access right after a limit load could see the old bound
      if (limitFresh && (b == SP_INDEX || m == MODE_STACK))
      begin
         reqValid = 1'b0;
         @(posedge clk_sys);
         #1;
      end
      limitFresh       = 1'b0;
      reqValid         = 1'b1;
      reqMode          = m;
      basePointerReg   = b;
      offsetWorkingReg = o;
      reqLiteral       = lit;
      fileAddr         = lit[12:0];
      stackKind        = k;
      pushValue        = pv;
      statusLowByte    = slb;
   endtask

   task automatic load_limit(input logic [15:0] v);
      @(posedge clk_sys);
      #1;
      reqValid    = 1'b0;
      limitWrEn   = 1'b1;
      limitWrData = v;
      limitFresh  = 1'b1;
   endtask

   task automatic idle();
      @(posedge clk_sys);
      #1;
      reqValid   = 1'b0;
      limitWrEn  = 1'b0;
      limitFresh = 1'b0;
   endtask
endmodule

// file: sim/tb.sv
// Self-checking bench for the stack check and address generator
`timescale 1ns/1ps
module tb;
   import scag_pkg::*;
   typedef struct {logic mv; logic chkW; logic wr; logic [15:0] ea; logic [15:0] wd;
                   logic trap; logic sec; logic [15:0] opa;} scag_note_s;
   logic        clk_sys, rst, reqValid, transferInstruction, fileToWorkingReg;
   logic        wregWrEn, limitWrEn, bootRamEn, secRamEn, execBootFlash, execSecFlash;
   logic        memValid, memWrite, stackErrorTrap, secureViolation;
   logic [7:0]  reqMode, statusLowByte;
   logic [3:0]  basePointerReg, offsetWorkingReg, stackKind, wregWrSel;
   logic [12:0] fileAddr;
   logic [15:0] reqLiteral, resultData, pushValue, wregWrData, limitWrData, bootRamLo;
   logic [15:0] bootRamHi, secRamLo, secRamHi, effectiveAddress, memWrData, operandA;
   logic [15:0] stackLimitReg, lim, wr [16];
   logic [31:0] seed = 40, r;
   int          miscompares, checks_done;
   scag_note_s  q [$];
   scag_note_s  n;

   scag_top i_dut (.clk_sys, .rst, .reqValid, .reqMode, .basePointerReg, .offsetWorkingReg,
      .reqLiteral, .fileAddr, .transferInstruction, .fileToWorkingReg, .resultData,
      .stackOp(1'b0), .stackKind, .pushValue, .statusLowByte, .wregWrEn, .wregWrSel,
      .wregWrData, .limitWrEn, .limitWrData, .bootRamEn, .bootRamLo, .bootRamHi, .secRamEn,
      .secRamLo, .secRamHi, .execBootFlash, .execSecFlash, .memValid, .memWrite,
      .effectiveAddress, .memWrData, .operandA, .stackLimitReg, .stackErrorTrap,
      .secureViolation);
   scag_decode_model i_dec (.clk_sys, .reqValid, .reqMode, .basePointerReg, .offsetWorkingReg,
      .reqLiteral, .fileAddr, .stackKind, .pushValue, .statusLowByte, .limitWrEn, .limitWrData);

   initial
   begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   task automatic chk(input logic [15:0] seen, exp);
      checks_done++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("[ERR] %0t ns mismatch: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic do_reset();
      rst = 1'b1;
      repeat (10) @(posedge clk_sys);
      #1;
      rst = 1'b0;
      lim = 16'hfffe;
      wr = '{default: DEFAULT_WORKING_REG_RESET};
      wr[15] = SP_RESET;
   endtask

   task automatic wset(input logic [3:0] s, input logic [15:0] v);
      @(posedge clk_sys);
      #1;
      wregWrEn = 1'b1;
      wregWrSel = s;
      wregWrData = v;
      wr[s] = v;
   endtask

   // Expected result is worked out here, before the request goes out
   task automatic op(input logic [7:0] m, input logic [3:0] b, o, input logic [15:0] lit,
                     pv = 16'h0000, input logic [3:0] k = STK_PUSH, input logic [7:0] slb = 8'h00);
      scag_note_s  e;
      logic [15:0] a;
      logic        stk;
      stk = (m == MODE_STACK);
      e.opa = wr[b];
      if (m == MODE_PRE) wr[b] = wr[b] + lit;
      a = stk ? (k == STK_POP ? wr[15] - WORD_STEP : wr[15]) :
          (m == MODE_FILE ? {3'h0, lit[12:0]} : wr[b]);
      if (m == MODE_INDEX) a = a + wr[o];
      if (m == MODE_LITOFS) a = a + lit;
      if (m == MODE_POST) wr[b] = wr[b] + lit;
      e.trap = (stk || b == SP_INDEX) && (a > lim || a < STACK_FLOOR);
      e.sec = (bootRamEn && a >= bootRamLo && a <= bootRamHi && !execBootFlash) ||
              (secRamEn && a >= secRamLo && a <= secRamHi && !execSecFlash);
      e.mv = !e.trap && !e.sec;
      e.chkW = stk;
      e.wr = stk && k != STK_POP;
      e.wd = k == STK_CALL_PUSH ? {1'b0, pv[14:0]} : (k == STK_EXC_PUSH ? {slb, pv[7:0]} : pv);
      e.ea = a;
      if (stk && e.mv) wr[15] = (k == STK_POP) ? a : wr[15] + WORD_STEP;
      if (m == MODE_FILE && fileToWorkingReg) wr[0] = resultData;
      q.push_back(e);
      i_dec.send(m, b, o, lit, pv, k, slb);
   endtask

   task automatic done_test(input string name);
      i_dec.idle();
      repeat (4) @(posedge clk_sys);
      #1;
      chk(16'(q.size()), 16'h0000);
      $display("test %s done", name);
   endtask

   // Outputs launch on the rising edge; look at them mid-cycle where they stand
   always @(negedge clk_sys)
   begin
      if (rst === 1'b0 && (memValid === 1'b1 || stackErrorTrap === 1'b1 || secureViolation === 1'b1))
      begin
         if (q.size() > 0)
            n = q.pop_front();
         else
            n = '{default: 'x};
         if (n.mv === 1'b1) chk(operandA, n.opa);
         chk(16'(stackErrorTrap), 16'(n.trap));
         chk(16'(secureViolation), 16'(n.sec));
         chk(16'(memValid), 16'(n.mv));
         if (n.mv === 1'b1) chk(effectiveAddress, n.ea);
         if (n.mv === 1'b1 && n.chkW === 1'b1) chk(16'(memWrite), 16'(n.wr));
         if (n.mv === 1'b1 && n.wr === 1'b1) chk(memWrData, n.wd);
      end
   end

   initial
   begin
      #80000;
      miscompares++;
      report_and_stop();
   end

   initial
   begin
      {transferInstruction, fileToWorkingReg, resultData, wregWrEn, wregWrSel, wregWrData} = '0;
      {bootRamEn, secRamEn, execBootFlash, execSecFlash} = 4'h0;
      {bootRamLo, bootRamHi, secRamLo, secRamHi} = {16'h2000, 16'h20ff, 16'h3000, 16'h30ff};
      miscompares = 0;
      checks_done = 0;
      do_reset();
      chk(stackLimitReg, 16'hfffe);
      op(MODE_STACK, SP_INDEX, 4'h0, 16'h0000, 16'h0000, STK_POP);
      op(MODE_STACK, SP_INDEX, 4'h0, 16'h0000, 16'h1234);
      op(MODE_STACK, SP_INDEX, 4'h0, 16'h0000, 16'h0000, STK_POP);
      done_test("stack basics");
      i_dec.load_limit(16'h0805);
      lim = 16'h0804;
      i_dec.idle();
      chk(stackLimitReg, lim);
      op(MODE_STACK, SP_INDEX, 4'h0, 16'h0000, 16'h0101);
      op(MODE_STACK, SP_INDEX, 4'h0, 16'h0000, 16'hffff, STK_CALL_PUSH);
      op(MODE_STACK, SP_INDEX, 4'h0, 16'h0000, 16'h12c3, STK_EXC_PUSH, 8'ha5);
      op(MODE_STACK, SP_INDEX, 4'h0, 16'h0000, 16'h5555);
      op(MODE_IND, SP_INDEX, 4'h0, 16'h0000);
      repeat (4) op(MODE_STACK, SP_INDEX, 4'h0, 16'h0000, 16'h0000, STK_POP);
      done_test("stack limit");
      for (int i = 1; i < 15; i++)
      begin
         r = rnd();
         wset(i[3:0], {4'h1, r[11:1], 1'b0});
      end
      @(posedge clk_sys);
      #1;
      wregWrEn = 1'b0;
      // Back-to-back modes also exercise the pointer write-back seen by the next request
      repeat (40)
      begin
         r = rnd();
         op(8'h04 << (r[2:0] % 5), 4'(r[7:4] % 14 + 1), 4'(r[11:8] % 14 + 1),
            {{11{r[20]}}, r[20:16]});
      end
      done_test("address modes");
      fileToWorkingReg = 1'b1;
      resultData = 16'h00a5;
      op(MODE_FILE, 4'h0, 4'h0, 16'hffff);
      op(MODE_IND, 4'h0, 4'h0, 16'h0000);
      done_test("file direct");
      transferInstruction = 1'b1;
      wset(4'h1, 16'hfff0);
      wset(4'h2, 16'h2010);
      wset(4'h3, 16'h3010);
      @(posedge clk_sys);
      #1;
      wregWrEn = 1'b0;
      op(MODE_IND, 4'h1, 4'h0, 16'h0000);
      for (int i = 0; i < 16; i++)
      begin
         i_dec.idle();
         {bootRamEn, execBootFlash, secRamEn, execSecFlash} = i[3:0];
         op(MODE_IND, 4'h2, 4'h0, 16'h0000);
         op(MODE_IND, 4'h3, 4'h0, 16'h0000);
      end
      done_test("secure windows");
      do_reset();
      chk(stackLimitReg, 16'hfffe);
      op(MODE_STACK, SP_INDEX, 4'h0, 16'h0000, 16'h0f0f);
      done_test("second reset");
      report_and_stop();
   end
endmodule
